// ===== rtl/sli_status_led.v
`timescale 1ns/10ps
`include "sli_consts.vh"
module sli_status_led #(
    parameter FLASH_CYCLES = (`SLI_CLK_HZ / 1000) * `SLI_FLASH_MS / 2,
    parameter NCONN = 8
) (
    // clock and reset
    input wire REF_CLK,
    input wire SRST,
    // condition inputs
    input wire [15:0] SENSED_INPUT_BIT,
    input wire [7:0] CONNECTOR_SHORT_FLAG,
    input wire [7:0] CONNECTOR_OVERLOAD,
    input wire CHANNEL_DIAG,
    input wire PRIMARY_SUPPLY_LOW,
    input wire SUPPLY_GOOD,
    input wire INTERNAL_LINK_FAULT,
    input wire POWER_ON,
    input wire MASTER_CONNECTED,
    input wire NODE_READY,
    input wire ONBOARD_LOGIC_ENGINE,
    input wire ADDR_CONFLICT,
    input wire RESTORE_MODE,
    input wire MODBUS_TIMEOUT,
    input wire IDENTIFY_ACTIVE,
    input wire NEGOTIATING,
    input wire AWAIT_ADDRESS,
    // register port
    input wire [`SLI_ADDR_W-1:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    // interrupt
    output wire IRQ,
    // leds
    output reg NET_LED_GREEN,
    output reg NET_LED_RED,
    output reg SUPPLY_OK_LED,
    output reg [15:0] IN_LED_GREEN,
    output reg [15:0] IN_LED_RED
);
    // ****************************************************************
    // network led states
    // ****************************************************************
    localparam [2:0] ST_OFF = 3'h0;
    localparam [2:0] ST_RED = 3'h1;
    localparam [2:0] ST_IDENT = 3'h2;
    localparam [2:0] ST_ALT = 3'h3;
    localparam [2:0] ST_CONN = 3'h4;
    localparam [2:0] ST_ENGINE = 3'h5;
    localparam [2:0] ST_READY = 3'h6;
    localparam [2:0] ST_IDLE = 3'h7;
    localparam BURST_SLOTS = `SLI_BURST_MS / (`SLI_FLASH_MS / 2);

    reg [15:0] word0_reg;
    reg [15:0] word1_reg;
    reg [15:0] word0_next;
    reg [2:0] net_state_reg;
    reg [2:0] net_state_next;
    reg [`SLI_IRQ_W-1:0] irq_stat_reg;
    reg [`SLI_IRQ_W-1:0] irq_en_reg;
    reg [`SLI_IRQ_W-1:0] irq_event;
    reg [15:0] prev_word0_reg;
    wire flash;
    wire flash_tick;
    wire burst_lit;
    integer i;

    // ****************************************************************
    // timebases
    // ****************************************************************
    sli_pulse_gen #(
        .PERIOD(FLASH_CYCLES)
    ) u_flash (
        .clk(REF_CLK),
        .srst(SRST),
        .toggle_reg(flash),
        .tick(flash_tick)
    );

    sli_burst_gen #(
        .SLOTS(BURST_SLOTS)
    ) u_burst (
        .clk(REF_CLK),
        .srst(SRST),
        .tick(flash_tick),
        .lit_reg(burst_lit)
    );

    // ****************************************************************
    // input image words
    // ****************************************************************
    always @* begin
        word0_next = 16'h0;
        word0_next[`SLI_W0_DIAG] = CHANNEL_DIAG;
        word0_next[`SLI_W0_VLOW] = PRIMARY_SUPPLY_LOW;
        word0_next[`SLI_W0_LINK] = INTERNAL_LINK_FAULT;
        word0_next[`SLI_W0_SHORT_LSB +: 8] = CONNECTOR_SHORT_FLAG;
    end

    always @(posedge REF_CLK) begin
        if (SRST) begin
            word0_reg <= 16'h0;
            word1_reg <= 16'h0;
            prev_word0_reg <= 16'h0;
        end else begin
            word0_reg <= word0_next;
            // input n is pin four (even) or pin two (odd) of connector n/2
            word1_reg <= SENSED_INPUT_BIT;
            prev_word0_reg <= word0_reg;
        end
    end

    // ****************************************************************
    // interrupts: rising edges of the status flags
    // ****************************************************************
    always @* begin
        irq_event = {`SLI_IRQ_W{1'b0}};
        irq_event[`SLI_IRQ_DIAG] = word0_reg[`SLI_W0_DIAG] & ~prev_word0_reg[`SLI_W0_DIAG];
        irq_event[`SLI_IRQ_VLOW] = word0_reg[`SLI_W0_VLOW] & ~prev_word0_reg[`SLI_W0_VLOW];
        irq_event[`SLI_IRQ_LINK] = word0_reg[`SLI_W0_LINK] & ~prev_word0_reg[`SLI_W0_LINK];
        irq_event[`SLI_IRQ_SHORT] = |(word0_reg[`SLI_W0_SHORT_LSB +: 8]
            & ~prev_word0_reg[`SLI_W0_SHORT_LSB +: 8]);
    end

    always @(posedge REF_CLK) begin
        if (SRST) begin
            irq_stat_reg <= {`SLI_IRQ_W{1'b0}};
            irq_en_reg <= {`SLI_IRQ_W{1'b0}};
        end else begin
            if (WR && ADDR == `SLI_REG_IRQ_EN)
                irq_en_reg <= WDATA[`SLI_IRQ_W-1:0];
            // set wins over clear
            if (WR && ADDR == `SLI_REG_IRQ_CLR)
                irq_stat_reg <= (irq_stat_reg & ~WDATA[`SLI_IRQ_W-1:0]) | irq_event;
            else
                irq_stat_reg <= irq_stat_reg | irq_event;
        end
    end

    assign IRQ = |(irq_stat_reg & irq_en_reg);

    // ****************************************************************
    // register reads
    // ****************************************************************
    always @(posedge REF_CLK) begin
        if (SRST) begin
            RDATA <= 16'h0;
        end else if (RD) begin
            if (ADDR == `SLI_REG_WORD0)
                RDATA <= word0_reg;
            else if (ADDR == `SLI_REG_WORD1)
                RDATA <= word1_reg;
            else if (ADDR == `SLI_REG_IRQ_STAT)
                RDATA <= {{(16-`SLI_IRQ_W){1'b0}}, irq_stat_reg};
            else if (ADDR == `SLI_REG_IRQ_EN)
                RDATA <= {{(16-`SLI_IRQ_W){1'b0}}, irq_en_reg};
            else if (ADDR == `SLI_REG_LED_STATE)
                RDATA <= {13'h0, net_state_reg};
            else
                RDATA <= 16'h0;
        end else begin
            RDATA <= 16'h0;
        end
    end

    // ****************************************************************
    // network led state, highest priority first
    // ****************************************************************
    always @* begin
        if (!POWER_ON)
            net_state_next = ST_OFF;
        else if (ADDR_CONFLICT || RESTORE_MODE || MODBUS_TIMEOUT)
            net_state_next = ST_RED;
        else if (IDENTIFY_ACTIVE)
            net_state_next = ST_IDENT;
        else if (NEGOTIATING || AWAIT_ADDRESS)
            net_state_next = ST_ALT;
        else if (MASTER_CONNECTED)
            net_state_next = ST_CONN;
        else if (ONBOARD_LOGIC_ENGINE)
            net_state_next = ST_ENGINE;
        else if (NODE_READY)
            net_state_next = ST_READY;
        else
            net_state_next = ST_IDLE;
    end

    always @(posedge REF_CLK) begin
        if (SRST)
            net_state_reg <= ST_OFF;
        else
            net_state_reg <= net_state_next;
    end

    always @(posedge REF_CLK) begin
        if (SRST) begin
            NET_LED_GREEN <= 1'b0;
            NET_LED_RED <= 1'b0;
        end else begin
            case (net_state_reg)
                ST_OFF: begin
                    NET_LED_GREEN <= 1'b0;
                    NET_LED_RED <= 1'b0;
                end
                ST_RED: begin
                    NET_LED_GREEN <= 1'b0;
                    NET_LED_RED <= 1'b1;
                end
                ST_IDENT: begin
                    NET_LED_GREEN <= 1'b0;
                    NET_LED_RED <= flash;
                end
                ST_ALT: begin
                    NET_LED_GREEN <= flash;
                    NET_LED_RED <= ~flash;
                end
                ST_CONN: begin
                    NET_LED_GREEN <= 1'b1;
                    NET_LED_RED <= 1'b0;
                end
                ST_ENGINE: begin
                    NET_LED_GREEN <= burst_lit;
                    NET_LED_RED <= 1'b0;
                end
                ST_READY: begin
                    NET_LED_GREEN <= flash;
                    NET_LED_RED <= 1'b0;
                end
                default: begin
                    NET_LED_GREEN <= 1'b0;
                    NET_LED_RED <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // supply and input leds
    // ****************************************************************
    always @(posedge REF_CLK) begin
        if (SRST) begin
            SUPPLY_OK_LED <= 1'b0;
            IN_LED_GREEN <= 16'h0;
            IN_LED_RED <= 16'h0;
        end else begin
            SUPPLY_OK_LED <= SUPPLY_GOOD;
            for (i = 0; i < 16; i = i + 1) begin
                if (CONNECTOR_OVERLOAD[i/2]) begin
                    IN_LED_GREEN[i] <= 1'b0;
                    IN_LED_RED[i] <= flash;
                end else begin
                    IN_LED_GREEN[i] <= SENSED_INPUT_BIT[i];
                    IN_LED_RED[i] <= 1'b0;
                end
            end
        end
    end
endmodule // sli_status_led

// ===== rtl/sli_consts.vh
`ifndef SLI_CONSTS_VH
`define SLI_CONSTS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define SLI_ADDR_W 4
`define SLI_REG_WORD0 4'h0
`define SLI_REG_WORD1 4'h1
`define SLI_REG_IRQ_STAT 4'h2
`define SLI_REG_IRQ_EN 4'h3
`define SLI_REG_IRQ_CLR 4'h4
`define SLI_REG_LED_STATE 4'h5
// ****************************************************************
// word 0 fields
// ****************************************************************
`define SLI_W0_DIAG 0
`define SLI_W0_VLOW 1
`define SLI_W0_LINK 3
`define SLI_W0_SHORT_LSB 8
// ****************************************************************
// interrupt status bits
// ****************************************************************
`define SLI_IRQ_W 4
`define SLI_IRQ_DIAG 0
`define SLI_IRQ_VLOW 1
`define SLI_IRQ_LINK 2
`define SLI_IRQ_SHORT 3
// ****************************************************************
// timing
// ****************************************************************
`define SLI_CLK_HZ 125000000
`define SLI_FLASH_MS 250
`define SLI_BURST_MS 2000
`define SLI_BURST_FLASHES 3
`endif

// ===== rtl/sli_pulse_gen.v
`timescale 1ns/10ps
// ****************************************************************
// free running flash timebase
// ****************************************************************
module sli_pulse_gen #(
    parameter PERIOD = 31250000
) (
    input wire clk,
    input wire srst,
    output reg toggle_reg,
    output reg tick
);
    reg [31:0] cnt_reg;
    always @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 32'h0;
            toggle_reg <= 1'b0;
            tick <= 1'b0;
        end else if (cnt_reg == PERIOD - 1) begin
            cnt_reg <= 32'h0;
            toggle_reg <= ~toggle_reg;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule // sli_pulse_gen

// ===== rtl/sli_burst_gen.v
`timescale 1ns/10ps
`include "sli_consts.vh"
// ****************************************************************
// burst of flashes per frame, counted in half-flash ticks
// ****************************************************************
module sli_burst_gen #(
    parameter SLOTS = 8
) (
    input wire clk,
    input wire srst,
    input wire tick,
    output reg lit_reg
);
    reg [7:0] slot_reg;
    always @(posedge clk) begin
        if (srst) begin
            slot_reg <= 8'h0;
            lit_reg <= 1'b0;
        end else if (tick) begin
            slot_reg <= (slot_reg == SLOTS - 1) ? 8'h0 : slot_reg + 8'h1;
            // even slots below twice the flash count are lit
            lit_reg <= (slot_reg < 2 * `SLI_BURST_FLASHES) && !slot_reg[0];
        end
    end
endmodule // sli_burst_gen

// ===== verification/sli_led_props.sv
`timescale 1ns/10ps
`include "sli_consts.vh"
module sli_led_props (
    // clock and reset
    input wire REF_CLK,
    input wire SRST,
    // conditions
    input wire [15:0] SENSED_INPUT_BIT,
    input wire [7:0] CONNECTOR_SHORT_FLAG,
    input wire [7:0] CONNECTOR_OVERLOAD,
    input wire CHANNEL_DIAG,
    input wire PRIMARY_SUPPLY_LOW,
    input wire SUPPLY_GOOD,
    input wire INTERNAL_LINK_FAULT,
    input wire POWER_ON,
    input wire MASTER_CONNECTED,
    input wire ADDR_CONFLICT,
    input wire RESTORE_MODE,
    input wire MODBUS_TIMEOUT,
    input wire IDENTIFY_ACTIVE,
    input wire NEGOTIATING,
    input wire AWAIT_ADDRESS,
    // register port
    input wire [`SLI_ADDR_W-1:0] ADDR,
    input wire RD,
    input wire [15:0] RDATA,
    // leds
    input wire NET_LED_GREEN,
    input wire NET_LED_RED,
    input wire SUPPLY_OK_LED,
    input wire [15:0] IN_LED_GREEN,
    input wire [15:0] IN_LED_RED
);
wire [15:0] ov16;
wire [15:0] w0 = {CONNECTOR_SHORT_FLAG, 4'h0, INTERNAL_LINK_FAULT, 1'b0,
    PRIMARY_SUPPLY_LOW, CHANNEL_DIAG};
wire red_c = ADDR_CONFLICT | RESTORE_MODE | MODBUS_TIMEOUT;
wire mid_c = IDENTIFY_ACTIVE | NEGOTIATING | AWAIT_ADDRESS;
for (genvar i = 0; i < 16; i++) begin : g_ov
    assign ov16[i] = CONNECTOR_OVERLOAD[i/2];
end
default clocking @(posedge REF_CLK); endclocking
default disable iff (SRST);
a_word0_read: assert property (RD && ADDR == `SLI_REG_WORD0 && $stable(w0) && !$past(SRST)
    |=> RDATA == $past(w0)) else $error("word0 read mismatch");
a_word1_read: assert property (RD && ADDR == `SLI_REG_WORD1 && $stable(SENSED_INPUT_BIT)
    && !$past(SRST) |=> RDATA == $past(SENSED_INPUT_BIT)) else $error("word1 read mismatch");
a_supply_led: assert property (!$past(SRST) |-> SUPPLY_OK_LED == $past(SUPPLY_GOOD))
    else $error("supply led wrong");
a_input_green: assert property (!$past(SRST)
    |-> IN_LED_GREEN == ($past(SENSED_INPUT_BIT) & ~$past(ov16))) else $error("input led wrong");
a_overload_red: assert property ((IN_LED_RED & ~$past(ov16)) == 16'h0)
    else $error("red on healthy connector");
a_net_dark: assert property ((!POWER_ON)[*2] |=> !NET_LED_GREEN && !NET_LED_RED)
    else $error("net led lit unpowered");
a_red_solid: assert property ((POWER_ON && red_c)[*2] |=> NET_LED_RED && !NET_LED_GREEN)
    else $error("net led not solid red");
a_ident_red: assert property ((POWER_ON && !red_c && IDENTIFY_ACTIVE)[*2]
    |=> !NET_LED_GREEN) else $error("identify shows green");
a_conn_green: assert property ((POWER_ON && !red_c && !mid_c && MASTER_CONNECTED)[*2]
    |=> NET_LED_GREEN && !NET_LED_RED) else $error("connected not green");
a_rdata_idle: assert property (!RD |=> RDATA == 16'h0)
    else $error("read data not idle");
endmodule // sli_led_props
bind sli_status_led sli_led_props u_sli_led_props (.REF_CLK, .SRST, .SENSED_INPUT_BIT,
    .CONNECTOR_SHORT_FLAG, .CONNECTOR_OVERLOAD, .CHANNEL_DIAG, .PRIMARY_SUPPLY_LOW,
    .SUPPLY_GOOD, .INTERNAL_LINK_FAULT, .POWER_ON, .MASTER_CONNECTED, .ADDR_CONFLICT,
    .RESTORE_MODE, .MODBUS_TIMEOUT, .IDENTIFY_ACTIVE, .NEGOTIATING, .AWAIT_ADDRESS, .ADDR,
    .RD, .RDATA, .NET_LED_GREEN, .NET_LED_RED, .SUPPLY_OK_LED, .IN_LED_GREEN, .IN_LED_RED);

// ===== verification/sli_ctrl_model.sv
`timescale 1ns/10ps
// ****************************************************************
// controller reading the input image
// ****************************************************************
module sli_ctrl_model (
    // clock
    input wire clk,
    // register port
    input wire [15:0] rdata,
    output logic [3:0] addr = 4'h0,
    output logic [15:0] wdata = 16'h0,
    output logic wr = 1'b0,
    output logic rd = 1'b0
);
task automatic put(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
endtask
task automatic get(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
endtask
endmodule // sli_ctrl_model

// ===== verification/sli_status_led_test.sv
`timescale 1ns/10ps
`include "sli_consts.vh"
module sli_status_led_test;
logic clk = 1'b0;
logic srst = 1'b1;
logic [15:0] sib = 16'h0, rdv, rdata, wdata, ilg, ilr;
logic [7:0] shf = 8'h0, ovl = 8'h0;
logic dg = 1'b0, vl = 1'b0, sg = 1'b0, lf = 1'b0, irq, ng, nr, sok, wr, rd;
logic [9:0] cv = 10'h0;
logic [3:0] addr;
logic [20:0] tbl [11] = '{{3'd0, 4'd0, 4'd0, 10'b0111111111}, {3'd1, 4'd0, 4'd0, 10'b1100000000},
    {3'd1, 4'd0, 4'd0, 10'b1010000000}, {3'd1, 4'd0, 4'd0, 10'b1001111111},
    {3'd2, 4'd0, 4'd8, 10'b1000111111}, {3'd3, 4'd8, 4'd8, 10'b1000011111},
    {3'd3, 4'd8, 4'd8, 10'b1000001111}, {3'd4, 4'd0, 4'd0, 10'b1000000111},
    {3'd5, 4'd3, 4'd0, 10'b1000000011}, {3'd6, 4'd8, 4'd0, 10'b1000000001},
    {3'd7, 4'd0, 4'd0, 10'b1000000000}};
int err_total = 0, checks_done = 0, cycles = 0, g, r;
always #4 clk = ~clk;
sli_ctrl_model u_sli_ctrl_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
sli_status_led #(.FLASH_CYCLES(4)) u_sli_status_led (.REF_CLK(clk), .SRST(srst),
    .SENSED_INPUT_BIT(sib), .CONNECTOR_SHORT_FLAG(shf), .CONNECTOR_OVERLOAD(ovl),
    .CHANNEL_DIAG(dg), .PRIMARY_SUPPLY_LOW(vl), .SUPPLY_GOOD(sg), .INTERNAL_LINK_FAULT(lf),
    .POWER_ON(cv[9]), .ADDR_CONFLICT(cv[8]), .RESTORE_MODE(cv[7]), .MODBUS_TIMEOUT(cv[6]),
    .IDENTIFY_ACTIVE(cv[5]), .NEGOTIATING(cv[4]), .AWAIT_ADDRESS(cv[3]),
    .MASTER_CONNECTED(cv[2]), .ONBOARD_LOGIC_ENGINE(cv[1]), .NODE_READY(cv[0]),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
    .NET_LED_GREEN(ng), .NET_LED_RED(nr), .SUPPLY_OK_LED(sok), .IN_LED_GREEN(ilg),
    .IN_LED_RED(ilr));
task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
        err_total++;
        wrap_up();
    end
end
task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
        err_total++;
        $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    u_sli_ctrl_model.get(a, rdv);
    chk("register", rdv, exp);
endtask
task automatic rises;
    logic pg, pr;
    g = 0;
    r = 0;
    repeat (64) begin
        pg = ng;
        pr = nr;
        w(1);
        g += int'(ng && !pg);
        r += int'(nr && !pr);
    end
endtask
// ****************************************************************
// main sequence
// ****************************************************************
initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
        @(posedge clk) sib <= 16'h1 << i;
        w(2);
        rdc(`SLI_REG_WORD1, 16'h1 << i);
        chk("input green", ilg, 16'h1 << i);
    end
    u_sli_ctrl_model.put(`SLI_REG_IRQ_EN, 16'h000b);
    @(posedge clk) {dg, vl, lf, shf} <= {3'b111, 8'h81};
    w(4);
    rdc(`SLI_REG_WORD0, 16'h810b);
    rdc(`SLI_REG_IRQ_STAT, 16'h000f);
    chk("irq", irq, 16'h1);
    u_sli_ctrl_model.put(`SLI_REG_IRQ_CLR, 16'h000b);
    w(1);
    chk("irq masked", irq, 16'h0);
    u_sli_ctrl_model.put(`SLI_REG_IRQ_EN, 16'h0004);
    w(1);
    chk("irq unmasked", irq, 16'h1);
    rdc(`SLI_REG_IRQ_EN, 16'h0004);
    u_sli_ctrl_model.put(`SLI_REG_IRQ_CLR, 16'h0004);
    rdc(`SLI_REG_IRQ_STAT, 16'h0000);
    // link fault rises in the very cycle its clear lands: the set must win
    @(posedge clk) lf <= 1'b0;
    w(3);
    @(posedge clk) lf <= 1'b1;
    u_sli_ctrl_model.put(`SLI_REG_IRQ_CLR, 16'h0004);
    rdc(`SLI_REG_IRQ_STAT, 16'h0004);
    u_sli_ctrl_model.put(`SLI_REG_WORD0, 16'hffff);
    rdc(`SLI_REG_WORD0, 16'h810b);
    rdc(4'hf, 16'h0000);
    @(posedge clk) {dg, vl, lf, shf, sg} <= {3'b000, 8'h00, 1'b1};
    w(3);
    rdc(`SLI_REG_WORD0, 16'h0000);
    chk("supply on", sok, 16'h1);
    @(posedge clk) {sg, sib, ovl} <= {1'b0, 16'h00ff, 8'h01};
    w(3);
    chk("supply off", sok, 16'h0);
    chk("overload green", ilg, 16'h00fc);
    g = 0;
    repeat (16) begin
        w(1);
        g += int'(ilr == 16'h0003);
    end
    chk("overload red", 16'(g), 16'd8);
    for (int k = 0; k < 11; k++) begin
        @(posedge clk) cv <= tbl[k][9:0];
        w(3);
        rdc(`SLI_REG_LED_STATE, 16'(tbl[k][20:18]));
        rises();
        chk("green rises", 16'(g), 16'(tbl[k][17:14]));
        chk("red rises", 16'(r), 16'(tbl[k][13:10]));
    end
    wrap_up();
end
endmodule // sli_status_led_test
